// ---- lcc_link_regs.sv ----
// Link capability and link control registers with their configuration access port
// What this block does
// - Port number field always reads zero
// - Capability bits 23:18 read zero
// - Common clock: deep latency from diag 20:18
// - Separate clocks: deep latency from diag 17:15
// - Common clock: shallow latency reads 011b
// - Separate clocks: shallow latency reads 100b
// - Power management support field reads 11b
// - Maximum lane width reads one lane
// - Maximum link rate reads 1h
// - Control bits 15:8 read zero
// - Extended sync lengthens FTS, adds TS2
// - Extended sync resets to zero
// - Common clock bit writable, selects latencies
// - Retrain request bit always reads zero
// - Link off bit always reads zero
// - Completion boundary stored only, own fixed
// - Control bit 2 reads zero
// - Power management control field, two bits
module lcc_link_regs #(
  parameter logic [7:0] FTS_NORMAL   = 8'h20,
  parameter logic [7:0] FTS_EXTENDED = 8'hFF
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Configuration access
  input  wire logic        cfgWrEn,
  input  wire logic        cfgRdEn,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic      [31:0] cfgRdData,
  output logic             cfgRdValid,
  // Diagnostic register latency fields
  input  wire logic [2:0]  deepExitLatFieldA,
  input  wire logic [2:0]  deepExitLatFieldB,
  // Link control to the link logic
  output logic             extendedSync,
  output logic             commonRefclkConfig,
  output logic             completionBoundary,
  output logic      [1:0]  activePmControl,
  output logic      [7:0]  ownComplBoundary,
  // Deep-sleep exit training lengths
  output logic      [7:0]  l1ExitFtsCount,
  output logic             l1ExitExtraTs2
);

  function automatic logic hitWord(input logic [7:0] addr, input logic [7:0] offset);
    return addr[7:2] == offset[7:2];
  endfunction

  logic [31:0] capWord;
  logic [15:0] ctrlQ;
  logic [15:0] ctrlD;
  logic [31:0] rdDataQ;
  logic [31:0] rdDataD;
  logic        rdValidQ;
  logic        rdValidD;
  logic [7:0]  rdAddrQ;
  logic [7:0]  rdAddrD;
  logic [7:0]  ftsQ;
  logic [7:0]  ftsD;
  logic        ts2Q;
  logic        ts2D;
  logic        afterRstQ;
  logic        ctrlWrHit;

  lcc_cap_word lcc_cap_word_i (
    .commonRefclkConfig (ctrlQ[lcc_pkg::COMMON_CLK_BIT]),
    .deepExitLatFieldA  (deepExitLatFieldA),
    .deepExitLatFieldB  (deepExitLatFieldB),
    .capWord            (capWord)
  );

  // Only byte lane 0 holds writable control bits; the capability word has none
  assign ctrlWrHit = cfgWrEn && cfgByteEn[0] && hitWord(cfgAddr, lcc_pkg::LINK_CTRL_OFFSET);

  always_comb begin
    ctrlD    = ctrlQ;
    rdDataD  = rdDataQ;
    rdValidD = 1'b0;
    rdAddrD  = rdAddrQ;
    if (ctrlWrHit) begin
      // Masked merge keeps reserved and read-only bits at zero
      ctrlD = (ctrlQ & ~lcc_pkg::CTRL_WRITE_MASK) | ({8'h00, cfgWrData[7:0]} & lcc_pkg::CTRL_WRITE_MASK);
    end
    if (cfgRdEn) begin
      rdValidD = 1'b1;
      rdAddrD  = cfgAddr;
      if (hitWord(cfgAddr, lcc_pkg::LINK_CAP_OFFSET)) begin
        rdDataD = capWord;
      end else if (hitWord(cfgAddr, lcc_pkg::LINK_CTRL_OFFSET)) begin
        rdDataD = {16'h0000, ctrlQ};
      end else begin
        rdDataD = 32'h0000_0000;
      end
    end
    if (ctrlQ[lcc_pkg::EXT_SYNC_BIT]) begin
      ftsD = FTS_EXTENDED;
      ts2D = 1'b1;
    end else begin
      ftsD = FTS_NORMAL;
      ts2D = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ     <= lcc_pkg::CTRL_RESET;
      rdDataQ   <= 32'h0000_0000;
      rdValidQ  <= 1'b0;
      rdAddrQ   <= 8'h00;
      ftsQ      <= FTS_NORMAL;
      ts2Q      <= 1'b0;
      afterRstQ <= 1'b0;
    end else begin
      ctrlQ     <= ctrlD;
      rdDataQ   <= rdDataD;
      rdValidQ  <= rdValidD;
      rdAddrQ   <= rdAddrD;
      ftsQ      <= ftsD;
      ts2Q      <= ts2D;
      afterRstQ <= 1'b1;
    end
  end

  assign cfgRdData          = rdDataQ;
  assign cfgRdValid         = rdValidQ;
  assign extendedSync       = ctrlQ[lcc_pkg::EXT_SYNC_BIT];
  assign commonRefclkConfig = ctrlQ[lcc_pkg::COMMON_CLK_BIT];
  assign completionBoundary = ctrlQ[lcc_pkg::COMPL_BND_BIT];
  assign activePmControl    = ctrlQ[lcc_pkg::ACTIVE_PM_LSB +: 2];
  // Bridge boundary never follows the stored bit
  assign ownComplBoundary   = lcc_pkg::OWN_COMPL_BOUNDARY;
  assign l1ExitFtsCount     = ftsQ;
  assign l1ExitExtraTs2     = ts2Q;

  // Read answers and control writes as named steps
  sequence capReadDone;
    cfgRdValid && hitWord(rdAddrQ, lcc_pkg::LINK_CAP_OFFSET);
  endsequence

  sequence ctrlReadDone;
    cfgRdValid && hitWord(rdAddrQ, lcc_pkg::LINK_CTRL_OFFSET);
  endsequence

  sequence ctrlWrite;
    ctrlWrHit;
  endsequence

  portNum_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capReadDone |-> cfgRdData[31:24] == 8'h00)
    else $error("port number not zero");

  capRsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capReadDone |-> cfgRdData[23:18] == 6'h00)
    else $error("capability reserved bits not zero");

  deepLat_common_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgRdEn && hitWord(cfgAddr, lcc_pkg::LINK_CAP_OFFSET) && commonRefclkConfig
      |=> cfgRdData[17:15] == $past(deepExitLatFieldA))
    else $error("deep latency wrong for common clock");

  deepLat_async_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgRdEn && hitWord(cfgAddr, lcc_pkg::LINK_CAP_OFFSET) && !commonRefclkConfig
      |=> cfgRdData[17:15] == $past(deepExitLatFieldB))
    else $error("deep latency wrong for separate clocks");

  shallowLat_common_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (capReadDone and $past(commonRefclkConfig)) |-> cfgRdData[14:12] == 3'h3)
    else $error("shallow latency not 011b");

  shallowLat_async_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (capReadDone and !$past(commonRefclkConfig)) |-> cfgRdData[14:12] == 3'h4)
    else $error("shallow latency not 100b");

  pmSupport_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capReadDone |-> cfgRdData[11:10] == 2'h3)
    else $error("power management support not 11b");

  laneWidth_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capReadDone |-> cfgRdData[9:4] == 6'h01)
    else $error("lane width not one");

  linkRate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    capReadDone |-> cfgRdData[3:0] == 4'h1)
    else $error("link rate not 1h");

  ctrlRsvd_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlReadDone |-> cfgRdData[31:8] == 24'h00_0000)
    else $error("control upper bits not zero");

  extSync_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite ##0 cfgWrData[7] |-> ##2 (l1ExitFtsCount == FTS_EXTENDED) && l1ExitExtraTs2)
    else $error("extended sync not applied");

  extSync_normal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite ##0 !cfgWrData[7] |-> ##2 (l1ExitFtsCount == FTS_NORMAL) && !l1ExitExtraTs2)
    else $error("normal sync not applied");

  extSync_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !afterRstQ |-> !extendedSync && (l1ExitFtsCount == FTS_NORMAL) && !l1ExitExtraTs2)
    else $error("extended sync not clear after reset");

  commonClk_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite |=> commonRefclkConfig == $past(cfgWrData[6]))
    else $error("common clock bit not stored");

  retrain_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlReadDone |-> !cfgRdData[5])
    else $error("retrain bit not zero");

  linkOff_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlReadDone |-> !cfgRdData[4])
    else $error("link off bit not zero");

  complBnd_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite ##1 (cfgRdEn && hitWord(cfgAddr, lcc_pkg::LINK_CTRL_OFFSET) && !cfgWrEn)
      |=> cfgRdData[3] == $past(cfgWrData[3], 2) && ownComplBoundary == 8'h80)
    else $error("completion boundary not stored");

  ctrlRsvd_bit2_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlReadDone |-> !cfgRdData[2])
    else $error("control bit 2 not zero");

  pmCtrl_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite |=> activePmControl == $past(cfgWrData[1:0]))
    else $error("power management control not stored");

  roWrite_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrlWrHit |=> $stable(ctrlQ))
    else $error("control changed without a write");

  roBits_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite |=> (ctrlQ & ~lcc_pkg::CTRL_WRITE_MASK) == 16'h0000)
    else $error("write reached a read-only bit");

  laneSkip_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgWrEn && !cfgByteEn[0] |=> $stable(ctrlQ))
    else $error("control changed by a write without lane 0");

  capWrite_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgWrEn && hitWord(cfgAddr, lcc_pkg::LINK_CAP_OFFSET) |=> $stable(ctrlQ))
    else $error("control changed by a capability write");

  ctrlRead_value_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlReadDone |-> cfgRdData[15:0] == $past(ctrlQ))
    else $error("control read does not match stored value");

  extSync_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite |=> extendedSync == $past(cfgWrData[7]))
    else $error("extended sync bit not stored");

  complBnd_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWrite |=> completionBoundary == $past(cfgWrData[3]))
    else $error("completion boundary bit not stored");

  ownBnd_fixed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ownComplBoundary == 8'h80)
    else $error("own completion boundary not 128 bytes");

  // Training lengths trail the extended sync bit by one register stage
  ftsCount_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    l1ExitFtsCount == ($past(extendedSync) ? FTS_EXTENDED : FTS_NORMAL))
    else $error("FTS count does not follow extended sync");

  extraTs2_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    l1ExitExtraTs2 == $past(extendedSync))
    else $error("extra TS2 does not follow extended sync");

  // Read port handshake
  rdValid_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgRdEn |=> cfgRdValid)
    else $error("read answer missing");

  rdValid_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfgRdEn |=> !cfgRdValid)
    else $error("read answer without a request");

  rdData_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfgRdEn |=> $stable(cfgRdData))
    else $error("read data changed without a request");

  unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgRdEn && !hitWord(cfgAddr, lcc_pkg::LINK_CAP_OFFSET) && !hitWord(cfgAddr, lcc_pkg::LINK_CTRL_OFFSET)
      |=> cfgRdData == 32'h0000_0000)
    else $error("unmapped read not zero");

  rstRead_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !afterRstQ |-> !cfgRdValid && (cfgRdData == 32'h0000_0000) && !commonRefclkConfig)
    else $error("read port not clear after reset");

endmodule

// ---- lcc_pkg.sv ----
// Offsets, field layout, fixed values and reset values of the link capability and control registers
package lcc_pkg;

  // Byte offsets in configuration space
  localparam logic [7:0]  LINK_CAP_OFFSET     = 8'h9C;
  localparam logic [7:0]  LINK_CTRL_OFFSET    = 8'hA0;

  // Capability word field positions
  localparam int          PORT_NUM_LSB        = 24;
  localparam int          CAP_RSVD_LSB        = 18;
  localparam int          DEEP_LAT_LSB        = 15;
  localparam int          SHALLOW_LAT_LSB     = 12;
  localparam int          PM_SUPPORT_LSB      = 10;
  localparam int          LANE_WIDTH_LSB      = 4;
  localparam int          LINK_RATE_LSB       = 0;

  // Capability word fixed values
  localparam logic [7:0]  PORT_NUMBER         = 8'h00;
  localparam logic [5:0]  CAP_RSVD_VALUE      = 6'h00;
  localparam logic [2:0]  SHALLOW_LAT_COMMON  = 3'h3;
  localparam logic [2:0]  SHALLOW_LAT_ASYNC   = 3'h4;
  localparam logic [1:0]  ACTIVE_PM_SUPPORT   = 2'h3;
  localparam logic [5:0]  MAX_LANE_WIDTH      = 6'h01;
  localparam logic [3:0]  MAX_LINK_RATE       = 4'h1;

  // Control register bit positions
  localparam int          EXT_SYNC_BIT        = 7;
  localparam int          COMMON_CLK_BIT      = 6;
  localparam int          RETRAIN_BIT         = 5;
  localparam int          LINK_OFF_BIT        = 4;
  localparam int          COMPL_BND_BIT       = 3;
  localparam int          CTRL_RSVD2_BIT      = 2;
  localparam int          ACTIVE_PM_LSB       = 0;

  // Control register writable bits and reset value
  localparam logic [15:0] CTRL_WRITE_MASK     = 16'h00CB;
  localparam logic [15:0] CTRL_RESET          = 16'h0000;

  // Completion boundary the bridge itself always uses, in bytes
  localparam logic [7:0]  OWN_COMPL_BOUNDARY  = 8'h80;

endpackage

// ---- lcc_cap_word.sv ----
// Assembles the read-only link capability word from fixed fields and the clocking selection
module lcc_cap_word (
  // Clocking selection
  input  wire logic        commonRefclkConfig,
  // Exit latency fields from the diagnostic register
  input  wire logic [2:0]  deepExitLatFieldA,
  input  wire logic [2:0]  deepExitLatFieldB,
  // Assembled word
  output logic      [31:0] capWord
);

  always_comb begin
    capWord = 32'h0000_0000;
    capWord[lcc_pkg::PORT_NUM_LSB +: 8] = lcc_pkg::PORT_NUMBER;
    capWord[lcc_pkg::CAP_RSVD_LSB +: 6] = lcc_pkg::CAP_RSVD_VALUE;
    if (commonRefclkConfig) begin
      capWord[lcc_pkg::DEEP_LAT_LSB +: 3]    = deepExitLatFieldA;
      capWord[lcc_pkg::SHALLOW_LAT_LSB +: 3] = lcc_pkg::SHALLOW_LAT_COMMON;
    end else begin
      capWord[lcc_pkg::DEEP_LAT_LSB +: 3]    = deepExitLatFieldB;
      capWord[lcc_pkg::SHALLOW_LAT_LSB +: 3] = lcc_pkg::SHALLOW_LAT_ASYNC;
    end
    capWord[lcc_pkg::PM_SUPPORT_LSB +: 2] = lcc_pkg::ACTIVE_PM_SUPPORT;
    capWord[lcc_pkg::LANE_WIDTH_LSB +: 6] = lcc_pkg::MAX_LANE_WIDTH;
    capWord[lcc_pkg::LINK_RATE_LSB +: 4]  = lcc_pkg::MAX_LINK_RATE;
  end

endmodule

// ---- lcc_link_partner.sv ----
// Link partner stand-in: diagnostic latency fields and L1 exit training seen
module lcc_link_partner #(
  parameter logic [2:0] DIAG_A = 3'h5,
  parameter logic [2:0] DIAG_B = 3'h2
) (
  // Diagnostic register fields
  output logic      [2:0] deepExitLatFieldA,
  output logic      [2:0] deepExitLatFieldB,
  // Training sent on L1 exit
  input  wire logic [7:0] l1ExitFtsCount,
  input  wire logic       l1ExitExtraTs2,
  output logic      [8:0] trainLen
);
  timeunit 1ns;
  timeprecision 100ps;

  // Diagnostic fields hold still, as the diagnostic register does between writes
  assign deepExitLatFieldA = DIAG_A;
  assign deepExitLatFieldB = DIAG_B;
  // Training seen on L1 exit: the FTS run plus the optional extra TS2
  assign trainLen = {1'b0, l1ExitFtsCount} + {8'h00, l1ExitExtraTs2};
endmodule

// ---- lcc_link_regs_tb.sv ----
// Self-checking bench for the link capability and control registers
module lcc_link_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] NORM = 8'h20;
  localparam logic [7:0] EXT  = 8'hFF;
  logic        core_clk, rst_n, cfgWrEn, cfgRdEn, cfgRdValid;
  logic [7:0]  cfgAddr, ownComplBoundary, l1ExitFtsCount;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData;
  logic [2:0]  fieldA, fieldB;
  logic [1:0]  activePmControl;
  logic        extendedSync, commonRefclkConfig, completionBoundary, l1ExitExtraTs2;
  logic [8:0]  trainLen;
  int          n_mismatch, total_checks;

  lcc_link_regs #(.FTS_NORMAL(NORM), .FTS_EXTENDED(EXT)) lcc_link_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .deepExitLatFieldA(fieldA), .deepExitLatFieldB(fieldB),
    .extendedSync(extendedSync), .commonRefclkConfig(commonRefclkConfig),
    .completionBoundary(completionBoundary), .activePmControl(activePmControl),
    .ownComplBoundary(ownComplBoundary), .l1ExitFtsCount(l1ExitFtsCount),
    .l1ExitExtraTs2(l1ExitExtraTs2));
  lcc_link_partner lcc_link_partner_i (
    .deepExitLatFieldA(fieldA), .deepExitLatFieldB(fieldB),
    .l1ExitFtsCount(l1ExitFtsCount), .l1ExitExtraTs2(l1ExitExtraTs2),
    .trainLen(trainLen));

  always #2 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfgWrEn = 1'b1; cfgAddr = a; cfgByteEn = be; cfgWrData = d;
    cyc();
    cfgWrEn = 1'b0;
  endtask

  // Read answer is registered: valid one cycle after the request edge; an idle cycle follows
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cfgRdEn = 1'b1; cfgAddr = a;
    cyc();
    cfgRdEn = 1'b0;
    chk({31'h0, cfgRdValid}, 32'h1);
    chk(cfgRdData, exp);
    cyc();
  endtask

  function automatic logic [31:0] capOf(input logic c);
    return {8'h00, 6'h00, c ? fieldA : fieldB, c ? 3'h3 : 3'h4, 2'h3, 6'h01, 4'h1};
  endfunction

  task automatic t_reset;
    rd(8'hA0, 32'h0);
    chk({28'h0, extendedSync, commonRefclkConfig, activePmControl}, 32'h0);
    chk({24'h0, l1ExitFtsCount}, {24'h0, NORM});
    rd(8'h9C, capOf(1'b0));
  endtask

  task automatic t_write_all;
    wr(8'hA0, 4'hF, 32'hFFFF_FFFF);
    chk({28'h0, extendedSync, commonRefclkConfig, activePmControl}, 32'hF);
    chk({31'h0, completionBoundary}, 32'h1);
    chk({24'h0, ownComplBoundary}, 32'h80);
    cyc();
    chk({23'h0, trainLen}, {24'h0, EXT} + 32'h1);
    rd(8'hA0, 32'h0000_00CB);
    rd(8'h9C, capOf(1'b1));
  endtask

  task automatic t_read_only;
    wr(8'h9C, 4'hF, 32'hFFFF_FFFF);
    rd(8'h9C, capOf(1'b1));
    wr(8'hA0, 4'hE, 32'h0);
    rd(8'hA0, 32'h0000_00CB);
    rd(8'h40, 32'h0);
  endtask

  task automatic t_pm_modes;
    for (int m = 0; m < 4; m++) begin
      wr(8'hA0, 4'h1, 32'(m));
      rd(8'hA0, 32'(m));
      chk({30'h0, activePmControl}, 32'(m));
    end
    rd(8'h9C, capOf(1'b0));
    chk({23'h0, trainLen}, {24'h0, NORM});
  endtask

  task automatic t_mid_reset;
    wr(8'hA0, 4'h1, 32'h0000_0088);
    rd(8'hA0, 32'h0000_0088);
    chk({31'h0, completionBoundary}, 32'h1);
    chk({24'h0, l1ExitFtsCount}, {24'h0, EXT});
    rst_n = 1'b0;
    cyc();
    chk({28'h0, extendedSync, completionBoundary, activePmControl}, 32'h0);
    chk({23'h0, trainLen}, {24'h0, NORM});
    chk({31'h0, cfgRdValid}, 32'h0);
    chk(cfgRdData, 32'h0);
    rst_n = 1'b1;
    rd(8'hA0, 32'h0);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0; rst_n = 1'b0; cfgWrEn = 1'b0; cfgRdEn = 1'b0;
    cfgAddr = 8'h00; cfgByteEn = 4'h0; cfgWrData = 32'h0;
    n_mismatch = 0; total_checks = 0;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_write_all();
    t_read_only();
    t_pm_modes();
    t_mid_reset();
    test_done();
  end

  initial begin
    #(4 * 2000);
    n_mismatch++;
    test_done();
  end
endmodule
